// ==== verification/ees_master.sv ====
module ees_master (
  input wire logic clk,
  input wire logic sdaBus,
  output logic scl,
  output logic sdaLow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic idle = 1'b1;
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One bit in 12 cycles: data moves mid-low, sampled late in high
  task automatic bitx(input logic b, output logic s);
    scl = 1'b0;
    tk(3);
    sdaLow = ~b;
    tk(3);
    scl = 1'b1;
    tk(6);
    s = sdaBus;
  endtask
  // Long low phase lets a device ack drain before the framing edge
  task automatic cond(input logic low1);
    scl = 1'b0;
    tk(3);
    sdaLow = low1;
    tk(5);
    scl = 1'b1;
    tk(6);
    sdaLow = ~low1;
    tk(6);
  endtask
  task automatic start();
    if (idle) begin
      // Clock stays parked high between frames
      tk(6);
      sdaLow = 1'b1;
      tk(6);
    end else begin
      cond(1'b0);
    end
    idle = 1'b0;
  endtask
  task automatic stop();
    cond(1'b1);
    idle = 1'b1;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(d[i], s);
    bitx(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, s);
      d[i] = s;
    end
    bitx(~ack, s);
  endtask
endmodule

// ==== verification/ees_slave_tb.sv ====
module ees_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ees_pkg::*;
  // Short programming time keeps the run brief
  localparam int PROG = 200;
  localparam logic [4:0] DEVT = DEV_TYPE_DFLT;
  logic sys_clk, rst_b, writeProtect, scl, mLow, sdaOut, sdaOe, progBusy, ack;
  logic [1:0] straps;
  logic [7:0] d;
  logic [7:0] mdl [0:32767];
  wire logic sdaBus;
  int seed = 32'hcf74;
  int cur, fail_count, n_tests, a;
  // Open drain line with pull-up
  assign sdaBus = (sdaOe ? sdaOut : 1'b1) & ~mLow;
  ees_slave #(.ProgCycles(PROG), .DevType(DEVT)) u_ees_slave (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .sclIn(scl),
    .sdaIn(sdaBus),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .writeProtect(writeProtect),
    .chip_select_strap_low(straps[0]),
    .chip_select_strap_high(straps[1]),
    .progBusy(progBusy)
  );
  ees_master u_ees_master (.clk(sys_clk), .sdaBus(sdaBus), .scl(scl), .sdaLow(mLow));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Write-direction probe only: a read probe would clash with device data
  task automatic probe(input logic [7:0] b, input logic exp);
    u_ees_master.start();
    u_ees_master.send(b, ack);
    chk({7'h0, ack}, {7'h0, exp});
    u_ees_master.stop();
  endtask
  task automatic setAddr(input int a);
    u_ees_master.start();
    u_ees_master.send({DEVT, straps, 1'b0}, ack);
    chk({7'h0, ack}, 8'h01);
    u_ees_master.send(a[15:8], ack);
    chk({7'h0, ack}, 8'h01);
    u_ees_master.send(a[7:0], ack);
    chk({7'h0, ack}, 8'h01);
    cur = a & 32'h7fff;
  endtask
  task automatic wr(input int a, input int n);
    int t0;
    setAddr(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      u_ees_master.send(d, ack);
      chk({7'h0, ack}, {7'h0, ~writeProtect});
      if (!writeProtect) mdl[(a & 32'h7fc0) | ((a + i) & 63)] = d;
    end
    u_ees_master.stop();
    t0 = $time;
    if (writeProtect) begin
      repeat (20) @(negedge sys_clk);
      chk({7'h0, progBusy}, 8'h00);
    end else begin
      chk({7'h0, progBusy}, 8'h01);
      probe({DEVT, straps, 1'b0}, 1'b0);
      while (progBusy === 1'b1 && $time - t0 < 4 * PROG) @(negedge sys_clk);
      chk({7'h0, progBusy}, 8'h00);
      chk({7'h0, ($time - t0) > 4 * (PROG - 40)}, 8'h01);
      probe({DEVT, straps, 1'b0}, 1'b1);
    end
  endtask
  // A negative address means a current-address read
  task automatic rd(input int a, input int n);
    if (a >= 0) setAddr(a);
    u_ees_master.start();
    u_ees_master.send({DEVT, straps, 1'b1}, ack);
    chk({7'h0, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      u_ees_master.recv(i < n - 1, d);
      chk(d, mdl[cur]);
      cur = (cur + 1) & 32'h7fff;
    end
    u_ees_master.stop();
  endtask
  initial begin
    #250000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    rst_b = 1'b0;
    writeProtect = 1'b0;
    straps = 2'($random(seed));
    repeat (12) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk({6'h0, sdaOe, progBusy}, 8'h00);
    for (int s = 0; s < 4; s++) begin
      if (s[1:0] != straps) probe({DEVT, s[1:0], 1'b0}, 1'b0);
    end
    probe({DEVT ^ 5'h10, straps, 1'b0}, 1'b0);
    probe({DEVT, straps, 1'b0}, 1'b1);
    $display("test address match done");
    wr(32'h7ffe, 66);
    wr(32'h8000, 2);
    rd(32'h7fc0, 64);
    $display("test page write done");
    rd(32'h7ffe, 3);
    rd(-1, 1);
    $display("test wrap and current read done");
    writeProtect = 1'b1;
    wr(32'h7fd0, 1);
    writeProtect = 1'b0;
    rd(32'h7fd0, 1);
    $display("test write protect done");
    a = ($random(seed) & 32'h7fc0) | 32'h3;
    wr(a, 1);
    rd(a, 1);
    $display("test random byte write done");
    report_and_stop();
  end
endmodule

// ==== verilog/ees_mem.sv ====
module ees_mem #(
  parameter int AW = 15,
  parameter int DW = 8
) (
  input wire logic clk,
  ees_mem_if.mem bus
);
  logic [DW-1:0] arr [2**AW];
  logic [DW-1:0] rdata_r;

  // Read data always registered; no reset on the cell array
  always_ff @(posedge clk) begin
    if (bus.we) begin
      arr[bus.addr] <= bus.wdata;
    end
    rdata_r <= arr[bus.addr];
  end

  assign bus.rdata = rdata_r;
endmodule

// ==== verilog/ees_mem_if.sv ====
interface ees_mem_if #(parameter int AW = 15, parameter int DW = 8);
  logic [AW-1:0] addr;
  logic we;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl(output addr, output we, output wdata, input rdata);
  modport mem(input addr, input we, input wdata, output rdata);
endinterface

// ==== verilog/ees_pkg.sv ====
package ees_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int PROG_TIME_MS = 10;
  // Longest time, so the division rounds down
  localparam int PROG_CYCLES = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int ADDR_W = 15;
  localparam int PAGE_W = 6;
  localparam int PAGE_BYTES = 64;
  localparam int BYTE_W = 8;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam int SYNC_N = 5;
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_WP = 2;
  localparam int SY_CSL = 3;
  localparam int SY_CSH = 4;
  // Idle bus lines float high
  localparam logic [SYNC_N-1:0] SYNC_RST = 5'h03;
  // Arbitrary value for the device-type prefix
  localparam logic [4:0] DEV_TYPE_DFLT = 5'h0b;
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
  localparam logic [PAGE_BYTES-1:0] VLD_RST = 64'h0;

  typedef enum logic [2:0] {
    S_IDLE, S_DEV, S_AHI, S_ALO, S_WDAT, S_RD, S_RACK, S_WSTOP
  } ees_state_e;
endpackage

// ==== verilog/ees_slave.sv ====
// How it works
// - Slave address upper five bits must equal the device-type prefix.
// - Next two address bits must match the two chip-select strap pins.
// - Last address bit: one means read, zero means write.
// - Matching address is acknowledged, then read or write proceeds.
// - Receiver pulls data low in the ninth clock to acknowledge.
// - In write mode every address byte, and each data byte unless write protected, is acknowledged.
// - Read: shift eight bits, release, sample master ack; no ack ends.
// - Byte write: address, two memory address bytes, one data byte, STOP.
// - STOP after written data starts programming; requests ignored meanwhile.
// - Page write accepts up to 64 bytes per programming cycle.
// - Each written byte increments only the six low address bits.
// - Extra bytes wrap within the page and overwrite earlier ones.
// - All buffered page bytes are committed in one programming cycle.
// - Busy device withholds address ack; acks again once finished.
// - Write protect: ack addresses, refuse first data byte, no programming.
// - Current-address read uses last address plus one, wrapping at top.
// - Dummy write sets the address, repeated START then reads it.
// - Sequential read advances the full counter after each byte.
// - START is data falling with clock high; STOP is data rising.
// - Programming lasts at most 10 ms with the interface disabled.
module ees_slave #(
  parameter int ProgCycles = ees_pkg::PROG_CYCLES,
  parameter logic [4:0] DevType = ees_pkg::DEV_TYPE_DFLT
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic writeProtect,
  input wire logic chip_select_strap_low,
  input wire logic chip_select_strap_high,
  output logic progBusy
);
  import ees_pkg::*;

  localparam int CW = $clog2(ProgCycles + 1);
  localparam logic [CW-1:0] PROG_LAST = CW'(ProgCycles - 1);
  localparam logic [CW-1:0] COMMIT_END = CW'(PAGE_BYTES);

  // Three-stage sampling; level accepted once stages two and three agree
  logic [SYNC_N-1:0] s1_r, s2_r, s3_r, lvl_r, prv_r;
  logic [SYNC_N-1:0] lvl_nxt;

  always_comb begin
    lvl_nxt = lvl_r;
    for (int i = 0; i < SYNC_N; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        lvl_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
      s3_r <= SYNC_RST;
      lvl_r <= SYNC_RST;
      prv_r <= SYNC_RST;
    end else begin
      s1_r <= {chip_select_strap_high, chip_select_strap_low, writeProtect, sdaIn, sclIn};
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
      prv_r <= lvl_r;
    end
  end

  logic sclHi, sclRise, sclFall, startCond, stopCond, wpLvl;
  assign sclHi = lvl_r[SY_SCL] & prv_r[SY_SCL];
  assign sclRise = lvl_r[SY_SCL] & ~prv_r[SY_SCL];
  assign sclFall = ~lvl_r[SY_SCL] & prv_r[SY_SCL];
  assign startCond = sclHi & ~lvl_r[SY_SDA] & prv_r[SY_SDA];
  assign stopCond = sclHi & lvl_r[SY_SDA] & ~prv_r[SY_SDA];
  assign wpLvl = lvl_r[SY_WP];

  ees_mem_if #(.AW(ADDR_W), .DW(BYTE_W)) arrIf();
  ees_mem_if #(.AW(PAGE_W), .DW(BYTE_W)) pgIf();
  ees_mem #(.AW(ADDR_W), .DW(BYTE_W)) uArray (.clk(sys_clk), .bus(arrIf));
  ees_mem #(.AW(PAGE_W), .DW(BYTE_W)) uPage (.clk(sys_clk), .bus(pgIf));

  ees_state_e st_r, st_nxt, tgt_r, tgt_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] rx_r, rx_nxt, tx_r, tx_nxt;
  logic [6:0] hi_r, hi_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [PAGE_BYTES-1:0] vld_r, vld_nxt;
  logic ackSlot_r, ackSlot_nxt, oe_r, oe_nxt, dirty_r, dirty_nxt, mAck_r, mAck_nxt;
  logic busy_r, busy_nxt;
  logic [CW-1:0] prog_r, prog_nxt;
  logic pgWe, byteDone, devMatch, rxState, startProg;

  assign devMatch = (rx_r[7:3] == DevType)
    && (rx_r[2:1] == {lvl_r[SY_CSH], lvl_r[SY_CSL]});
  assign rxState = (st_r == S_DEV) || (st_r == S_AHI) || (st_r == S_ALO)
    || (st_r == S_WDAT);

  always_comb begin
    st_nxt = st_r;
    tgt_nxt = tgt_r;
    bit_nxt = bit_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    hi_nxt = hi_r;
    addr_nxt = addr_r;
    vld_nxt = vld_r;
    ackSlot_nxt = ackSlot_r;
    oe_nxt = oe_r;
    dirty_nxt = dirty_r;
    mAck_nxt = mAck_r;
    pgWe = 1'b0;
    byteDone = 1'b0;
    if (startCond) begin
      oe_nxt = 1'b0;
      ackSlot_nxt = 1'b0;
      bit_nxt = 4'h0;
      // Busy device stays deaf, so polling sees no ack
      st_nxt = busy_r ? S_IDLE : S_DEV;
    end else if (stopCond) begin
      oe_nxt = 1'b0;
      ackSlot_nxt = 1'b0;
      st_nxt = S_IDLE;
      dirty_nxt = 1'b0;
    end else if (sclRise) begin
      if (rxState && !ackSlot_r && bit_r < ACK_BIT) begin
        rx_nxt = {rx_r[6:0], lvl_r[SY_SDA]};
        bit_nxt = bit_r + 4'h1;
      end else if (st_r == S_RD) begin
        bit_nxt = bit_r + 4'h1;
      end else if (st_r == S_RACK) begin
        mAck_nxt = ~lvl_r[SY_SDA];
        addr_nxt = addr_r + 15'h0001;
      end
    end else if (sclFall) begin
      if (ackSlot_r) begin
        ackSlot_nxt = 1'b0;
        oe_nxt = 1'b0;
        bit_nxt = 4'h0;
        st_nxt = tgt_r;
        if (tgt_r == S_RD) begin
          tx_nxt = arrIf.rdata;
          oe_nxt = ~arrIf.rdata[7];
        end
      end else if (rxState && bit_r == ACK_BIT) begin
        byteDone = 1'b1;
        ackSlot_nxt = 1'b1;
        unique case (st_r)
          S_DEV: begin
            if (devMatch) begin
              oe_nxt = 1'b1;
              tgt_nxt = rx_r[0] ? S_RD : S_AHI;
            end else begin
              tgt_nxt = S_WSTOP;
            end
          end
          S_AHI: begin
            oe_nxt = 1'b1;
            hi_nxt = rx_r[6:0];
            tgt_nxt = S_ALO;
          end
          S_ALO: begin
            oe_nxt = 1'b1;
            addr_nxt = {hi_r, rx_r};
            vld_nxt = VLD_RST;
            tgt_nxt = S_WDAT;
          end
          S_WDAT: begin
            if (wpLvl) begin
              tgt_nxt = S_WSTOP;
            end else begin
              oe_nxt = 1'b1;
              pgWe = 1'b1;
              vld_nxt[addr_r[PAGE_W-1:0]] = 1'b1;
              addr_nxt = {addr_r[ADDR_W-1:PAGE_W], addr_r[PAGE_W-1:0] + 6'h01};
              dirty_nxt = 1'b1;
              tgt_nxt = S_WDAT;
            end
          end
          default: begin
            tgt_nxt = S_WSTOP;
          end
        endcase
      end else if (st_r == S_RD) begin
        if (bit_r < ACK_BIT) begin
          tx_nxt = {tx_r[6:0], 1'b0};
          oe_nxt = ~tx_r[6];
        end else begin
          oe_nxt = 1'b0;
          bit_nxt = 4'h0;
          st_nxt = S_RACK;
        end
      end else if (st_r == S_RACK) begin
        if (mAck_r) begin
          tx_nxt = arrIf.rdata;
          oe_nxt = ~arrIf.rdata[7];
          bit_nxt = 4'h0;
          st_nxt = S_RD;
        end else begin
          oe_nxt = 1'b0;
          st_nxt = S_WSTOP;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= S_IDLE;
      tgt_r <= S_IDLE;
      bit_r <= 4'h0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      hi_r <= 7'h00;
      addr_r <= ADDR_RST;
      vld_r <= VLD_RST;
      ackSlot_r <= 1'b0;
      oe_r <= 1'b0;
      dirty_r <= 1'b0;
      mAck_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tgt_r <= tgt_nxt;
      bit_r <= bit_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      hi_r <= hi_nxt;
      addr_r <= addr_nxt;
      vld_r <= vld_nxt;
      ackSlot_r <= ackSlot_nxt;
      oe_r <= oe_nxt;
      dirty_r <= dirty_nxt;
      mAck_r <= mAck_nxt;
    end
  end

  // Programming timer; page commit runs in its first 65 cycles
  assign startProg = stopCond && dirty_r && !busy_r;

  always_comb begin
    busy_nxt = busy_r;
    prog_nxt = prog_r;
    if (startProg) begin
      busy_nxt = 1'b1;
      prog_nxt = '0;
    end else if (busy_r) begin
      prog_nxt = prog_r + CW'(1);
      if (prog_r == PROG_LAST) begin
        busy_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_r <= 1'b0;
      prog_r <= '0;
    end else begin
      busy_r <= busy_nxt;
      prog_r <= prog_nxt;
    end
  end

  logic [PAGE_W-1:0] cIdx;
  logic commitWe;
  assign cIdx = PAGE_W'(prog_r - CW'(1));
  // Page buffer read one cycle ahead of the array write
  assign commitWe = busy_r && prog_r != '0 && prog_r <= COMMIT_END && vld_r[cIdx];
  assign pgIf.addr = busy_r ? prog_r[PAGE_W-1:0] : addr_r[PAGE_W-1:0];
  assign pgIf.we = pgWe;
  assign pgIf.wdata = rx_r;
  assign arrIf.addr = busy_r ? {addr_r[ADDR_W-1:PAGE_W], cIdx} : addr_r;
  assign arrIf.we = commitWe;
  assign arrIf.wdata = pgIf.rdata;

  // Open drain: only ever pulls low
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
      progBusy <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
      sdaOe <= oe_nxt;
      progBusy <= busy_nxt;
    end
  end

  a_busy_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
    busy_r |-> !oe_r && st_r == S_IDLE)
    else $error("Bus answered while programming");
  a_prog_bound: assert property (@(posedge sys_clk) disable iff (!rst_b)
    busy_r |-> prog_r <= PROG_LAST)
    else $error("Programming ran too long");
  a_stop_starts: assert property (@(posedge sys_clk) disable iff (!rst_b)
    stopCond && dirty_r && !busy_r |=> busy_r ##1 busy_r)
    else $error("Programming did not start on STOP");
  a_dev_ack: assert property (@(posedge sys_clk) disable iff (!rst_b)
    byteDone && st_r == S_DEV && devMatch |=> oe_r && ackSlot_r)
    else $error("Matching address not acknowledged");
  a_dev_nack: assert property (@(posedge sys_clk) disable iff (!rst_b)
    byteDone && st_r == S_DEV && !devMatch |=> !oe_r && tgt_r == S_WSTOP)
    else $error("Foreign address acknowledged");
  a_wp_refuse: assert property (@(posedge sys_clk) disable iff (!rst_b)
    byteDone && st_r == S_WDAT && wpLvl |=> !oe_r && !dirty_r)
    else $error("Protected data byte accepted");
  a_page_wrap: assert property (@(posedge sys_clk) disable iff (!rst_b)
    byteDone && st_r == S_WDAT && !wpLvl |=>
    addr_r == {$past(addr_r[ADDR_W-1:PAGE_W]), 6'($past(addr_r[PAGE_W-1:0]) + 6'h01)})
    else $error("Page address step wrong");
  a_read_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sclRise && st_r == S_RACK && !startCond && !stopCond |=>
    addr_r == 15'($past(addr_r) + 15'h0001))
    else $error("Read address did not advance");
  a_start_seen: assert property (@(posedge sys_clk) disable iff (!rst_b)
    startCond && !busy_r |=> st_r == S_DEV && bit_r == 4'h0)
    else $error("START not recognised");

  c_read_byte: cover property (@(posedge sys_clk) disable iff (!rst_b)
    st_r == S_RACK && sclFall && mAck_r);
  c_page_prog: cover property (@(posedge sys_clk) disable iff (!rst_b) startProg);
  c_poll_nack: cover property (@(posedge sys_clk) disable iff (!rst_b)
    startCond && busy_r);
endmodule
